//--- rtl/serial_port_pkg.sv
// constants and register map of the serial register-access port
package serial_port_pkg;
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 15;
    localparam int DATA_BITS = 8;
    localparam logic [3:0] HEAD_LAST = 4'hf;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [4:0] HOST_HEAD_LAST = 5'h0f;
    localparam logic [4:0] HOST_FRAME_LAST = 5'h17;
    localparam logic [4:0] HOST_DATA_FIRST = 5'h10;

    localparam int CLOCK_PERIOD_NS = 10;
    localparam int LINK_PERIOD_NS = 80;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLOCK_PERIOD_NS);
    localparam int MIN_HALF_CYCLES = 4;

    localparam logic [14:0] ADDR_CONFIG_A = 15'h0000;
    localparam logic [14:0] ADDR_PART_TYPE = 15'h0003;
    localparam logic [14:0] ADDR_PART_ID_LO = 15'h0004;
    localparam logic [14:0] ADDR_PART_ID_HI = 15'h0005;
    localparam logic [14:0] ADDR_MAKER_LO = 15'h000c;
    localparam logic [14:0] ADDR_MAKER_HI = 15'h000d;
    localparam logic [14:0] ADDR_USER_SERIAL_CONFIG = 15'h0010;
    localparam logic [14:0] ADDR_SYNC_CAPTURE = 15'h002c;
    localparam logic [14:0] ADDR_CAL_STATE = 15'h006a;

    localparam int ASC_HI_BIT = 5;
    localparam int ASC_LO_BIT = 2;
    localparam int ADDR_HOLD_BIT = 0;

    localparam int NUM_RW = 38;
    localparam int FUSE_BASE = 26;
    localparam int NUM_FUSE = 12;
    localparam int IDX_W = 6;

    // writable bytes; 16-bit ranges occupy low byte then high byte
    localparam logic [14:0] RW_ADDR [NUM_RW] = '{
        15'h0000, 15'h0002, 15'h0010, 15'h0029, 15'h002a, 15'h002b, 15'h0030, 15'h0031,
        15'h0032, 15'h0033, 15'h0038, 15'h003b, 15'h0048, 15'h0060, 15'h0061, 15'h0062,
        15'h0064, 15'h0068, 15'h006b, 15'h006c, 15'h006e, 15'h0070, 15'h0071, 15'h0160,
        15'h0200, 15'h0201,
        15'h007a, 15'h007b, 15'h007c, 15'h007e, 15'h007f, 15'h009d, 15'h0102, 15'h0103,
        15'h0112, 15'h0113, 15'h0142, 15'h0152};
    // entries from FUSE_BASE up take their value from fuse memory
    localparam logic [7:0] RW_RESET [NUM_RW] = '{
        8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'ha0,
        8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
        8'h02, 8'h61, 8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h00,
        8'h01, 8'h02,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};

    // index of a writable byte, NUM_RW when the offset is not writable
    function automatic logic [IDX_W-1:0] rwIndex(input logic [14:0] a);
        logic [IDX_W-1:0] idx;
        idx = IDX_W'(NUM_RW);
        for (int i = 0; i < NUM_RW; i++) begin
            if (RW_ADDR[i] == a) begin
                idx = IDX_W'(i);
            end
        end
        return idx;
    endfunction
endpackage

//--- rtl/serial_port_if.sv
// four-wire serial link between host and device
`timescale 1ns/1ps
interface serial_port_if;
    logic serialClock;
    logic portSelectN;
    logic serialIn;
    logic serialOut;
    logic serialOutEnN;
    logic serialOutLine;

    // undriven line reads high, as with a pull-up
    assign serialOutLine = serialOutEnN ? 1'b1 : serialOut;

    modport device (
        input serialClock,
        input portSelectN,
        input serialIn,
        output serialOut,
        output serialOutEnN
    );
    modport host (
        output serialClock,
        output portSelectN,
        output serialIn,
        input serialOutLine
    );
endinterface

//--- rtl/serial_port_device.sv
// device end: frame decoder and register map behind the serial link
`timescale 1ns/1ps
module serial_port_device #(
    parameter logic [7:0] PART_TYPE = 8'h5a,
    parameter logic [15:0] PART_ID = 16'h1234,
    parameter logic [15:0] MAKER = 16'h00a5
) (
    input wire logic clock,
    input wire logic sys_rst,
    serial_port_if.device link,
    input wire logic [serial_port_pkg::NUM_FUSE*8-1:0] fuseTrim,
    input wire logic [7:0] syncCapturePos,
    input wire logic [7:0] calState,
    output logic writeStrobe,
    output logic [serial_port_pkg::ADDR_BITS-1:0] writeAddr,
    output logic [serial_port_pkg::DATA_BITS-1:0] writeData
);
    import serial_port_pkg::*;

    // identification values above are arbitrary

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HEADER = 3'b010,
        ST_DATA = 3'b100
    } dev_state_t;

    logic clkSync1, clkSync2, clkPrev;
    logic selSync1, selSync2;
    logic sinSync1, sinSync2;
    logic rise, fall;

    dev_state_t state, next_state;
    logic [3:0] bitCnt, next_bitCnt;
    logic [15:0] shiftIn, next_shiftIn;
    logic isRead, next_isRead;
    logic [14:0] addr, next_addr;
    logic [7:0] readShift, next_readShift;
    logic serialOutReg, next_serialOut;
    logic outEnN, next_outEnN;
    logic next_writeStrobe;
    logic [14:0] next_writeAddr;
    logic [7:0] next_writeData;

    logic [7:0] regFile [NUM_RW];
    logic wrEn;
    logic [IDX_W-1:0] wrIdx;
    logic [7:0] wrVal;
    logic [7:0] rxByte;
    logic [14:0] headAddr;
    logic [14:0] stepped;

    // all link pins cross two flops before any logic looks at them
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clkSync1 <= 1'b0;
            clkSync2 <= 1'b0;
            clkPrev <= 1'b0;
            selSync1 <= 1'b1;
            selSync2 <= 1'b1;
            sinSync1 <= 1'b0;
            sinSync2 <= 1'b0;
        end else begin
            clkSync1 <= link.serialClock;
            clkSync2 <= clkSync1;
            clkPrev <= clkSync2;
            selSync1 <= link.portSelectN;
            selSync2 <= selSync1;
            sinSync1 <= link.serialIn;
            sinSync2 <= sinSync1;
        end
    end

    // edges found on the sampled clock; a stopped clock just waits
    assign rise = clkSync2 & ~clkPrev;
    assign fall = ~clkSync2 & clkPrev;

    function automatic logic [7:0] readByte(input logic [14:0] a);
        logic [IDX_W-1:0] idx;
        idx = rwIndex(a);
        case (a)
            ADDR_PART_TYPE: readByte = PART_TYPE;
            ADDR_PART_ID_LO: readByte = PART_ID[7:0];
            ADDR_PART_ID_HI: readByte = PART_ID[15:8];
            ADDR_MAKER_LO: readByte = MAKER[7:0];
            ADDR_MAKER_HI: readByte = MAKER[15:8];
            ADDR_SYNC_CAPTURE: readByte = syncCapturePos;
            ADDR_CAL_STATE: readByte = calState;
            default: begin
                if (idx < IDX_W'(NUM_RW)) begin
                    readByte = regFile[idx];
                end else begin
                    readByte = 8'h00;
                end
            end
        endcase
    endfunction

    // streaming address step; either copy of the ascending bit counts
    function automatic logic [14:0] stepAddr(input logic [14:0] a);
        logic asc;
        logic hold;
        asc = regFile[0][ASC_HI_BIT] | regFile[0][ASC_LO_BIT];
        hold = regFile[2][ADDR_HOLD_BIT];
        if (hold) begin
            stepAddr = a;
        end else if (asc) begin
            stepAddr = a + 15'h0001;
        end else begin
            stepAddr = a - 15'h0001;
        end
    endfunction

    assign rxByte = {shiftIn[6:0], sinSync2};
    assign headAddr = {shiftIn[13:0], sinSync2};
    assign stepped = stepAddr(addr);

    always_comb begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_shiftIn = shiftIn;
        next_isRead = isRead;
        next_addr = addr;
        next_readShift = readShift;
        next_serialOut = serialOutReg;
        next_outEnN = outEnN;
        next_writeStrobe = 1'b0;
        next_writeAddr = writeAddr;
        next_writeData = writeData;
        wrEn = 1'b0;
        wrIdx = rwIndex(addr);
        wrVal = rxByte;
        if (addr == ADDR_CONFIG_A) begin
            wrVal[ASC_HI_BIT] = rxByte[ASC_HI_BIT] | rxByte[ASC_LO_BIT];
            wrVal[ASC_LO_BIT] = rxByte[ASC_HI_BIT] | rxByte[ASC_LO_BIT];
        end
        if (selSync2) begin
            // release drops any partial byte and rearms the counter
            next_state = ST_IDLE;
            next_bitCnt = 4'h0;
            next_outEnN = 1'b1;
        end else begin
            if (state == ST_IDLE) begin
                next_state = ST_HEADER;
            end
            if (rise) begin
                next_shiftIn = {shiftIn[14:0], sinSync2};
                if (state != ST_DATA) begin
                    if (bitCnt == HEAD_LAST) begin
                        next_isRead = shiftIn[14];
                        next_addr = headAddr;
                        next_readShift = readByte(headAddr);
                        next_bitCnt = 4'h0;
                        next_state = ST_DATA;
                    end else begin
                        next_bitCnt = bitCnt + 4'h1;
                    end
                end else if (bitCnt == DATA_LAST) begin
                    // read frames ignore the input byte
                    if (!isRead && wrIdx < IDX_W'(NUM_RW)) begin
                        wrEn = 1'b1;
                        next_writeStrobe = 1'b1;
                        next_writeAddr = addr;
                        next_writeData = wrVal;
                    end
                    next_addr = stepped;
                    next_readShift = readByte(stepped);
                    next_bitCnt = 4'h0;
                end else begin
                    next_bitCnt = bitCnt + 4'h1;
                end
            end
            if (fall && state == ST_DATA && isRead) begin
                next_serialOut = readShift[7];
                next_readShift = {readShift[6:0], 1'b0};
                next_outEnN = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            shiftIn <= 16'h0000;
            isRead <= 1'b0;
            addr <= 15'h0000;
            readShift <= 8'h00;
            serialOutReg <= 1'b0;
            outEnN <= 1'b1;
            writeStrobe <= 1'b0;
            writeAddr <= 15'h0000;
            writeData <= 8'h00;
        end else begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            shiftIn <= next_shiftIn;
            isRead <= next_isRead;
            addr <= next_addr;
            readShift <= next_readShift;
            serialOutReg <= next_serialOut;
            outEnN <= next_outEnN;
            writeStrobe <= next_writeStrobe;
            writeAddr <= next_writeAddr;
            writeData <= next_writeData;
        end
    end

    // register map; reset is synchronous so fuse values can be loaded
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_RW; i++) begin
                if (i >= FUSE_BASE) begin
                    regFile[i] <= fuseTrim[(i-FUSE_BASE)*8 +: 8];
                end else begin
                    regFile[i] <= RW_RESET[i];
                end
            end
        end else if (wrEn) begin
            regFile[wrIdx] <= wrVal;
        end
    end

    assign link.serialOut = serialOutReg;
    assign link.serialOutEnN = outEnN;
endmodule

//--- rtl/serial_port_host.sv
// host end: frames single and streaming accesses onto the serial link
`timescale 1ns/1ps
module serial_port_host #(
    parameter int HALF_CYCLES = serial_port_pkg::LINK_HALF_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    serial_port_if.host link,
    input wire logic start,
    input wire logic readNotWrite,
    input wire logic [serial_port_pkg::ADDR_BITS-1:0] address,
    input wire logic [7:0] byteCount,
    input wire logic [serial_port_pkg::DATA_BITS-1:0] writeData,
    input wire logic calRunning,
    output logic writeTake,
    output logic [serial_port_pkg::DATA_BITS-1:0] readData,
    output logic readValid,
    output logic busy
);
    import serial_port_pkg::*;

    // device samples through two flops, so read data needs this margin
    if (HALF_CYCLES < MIN_HALF_CYCLES || HALF_CYCLES > 255) begin : g_check
        $error("HALF_CYCLES out of range");
    end

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOW = 4'b0010,
        ST_HIGH = 4'b0100,
        ST_TRAIL = 4'b1000
    } host_state_t;

    host_state_t state, next_state;
    logic [7:0] phase, next_phase;
    logic [4:0] bitCnt, next_bitCnt;
    logic [7:0] bytesLeft, next_bytesLeft;
    logic [23:0] txShift, next_txShift;
    logic [7:0] rxShift, next_rxShift;
    logic isRead, next_isRead;
    logic selN, next_selN;
    logic sclk, next_sclk;
    logic next_writeTake;
    logic [7:0] next_readData;
    logic next_readValid;
    logic outSync1, outSync2;
    logic phaseDone;
    logic mapped;

    assign phaseDone = phase == 8'(HALF_CYCLES - 1);
    assign mapped = rwIndex(address) < IDX_W'(NUM_RW);

    always_comb begin
        next_state = state;
        next_phase = phaseDone ? 8'h00 : phase + 8'h01;
        next_bitCnt = bitCnt;
        next_bytesLeft = bytesLeft;
        next_txShift = txShift;
        next_rxShift = rxShift;
        next_isRead = isRead;
        next_selN = selN;
        next_sclk = sclk;
        next_writeTake = 1'b0;
        next_readData = readData;
        next_readValid = 1'b0;
        case (state)
            ST_IDLE: begin
                next_phase = 8'h00;
                // unmapped writes and accesses during calibration are refused
                if (start && !calRunning && byteCount != 8'h00 && (readNotWrite || mapped)) begin
                    next_state = ST_LOW;
                    next_selN = 1'b0;
                    next_isRead = readNotWrite;
                    next_txShift = {readNotWrite, address, writeData};
                    next_writeTake = !readNotWrite;
                    next_bytesLeft = byteCount;
                    next_bitCnt = 5'h00;
                end
            end
            ST_LOW: begin
                if (phaseDone) begin
                    next_sclk = 1'b1;
                    next_state = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (phaseDone) begin
                    next_sclk = 1'b0;
                    next_state = ST_LOW;
                    next_txShift = {txShift[22:0], 1'b0};
                    next_bitCnt = bitCnt + 5'h01;
                    if (isRead && bitCnt >= HOST_DATA_FIRST) begin
                        next_rxShift = {rxShift[6:0], outSync2};
                    end
                    if (bitCnt == HOST_FRAME_LAST) begin
                        next_readData = {rxShift[6:0], outSync2};
                        next_readValid = isRead;
                        next_bytesLeft = bytesLeft - 8'h01;
                        next_bitCnt = HOST_DATA_FIRST;
                        if (bytesLeft == 8'h01) begin
                            next_state = ST_TRAIL;
                        end else begin
                            next_txShift = {writeData, 16'h0000};
                            next_writeTake = !isRead;
                        end
                    end
                end
            end
            ST_TRAIL: begin
                if (phaseDone) begin
                    next_selN = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_selN = 1'b1;
                next_sclk = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            phase <= 8'h00;
            bitCnt <= 5'h00;
            bytesLeft <= 8'h00;
            txShift <= 24'h000000;
            rxShift <= 8'h00;
            isRead <= 1'b0;
            selN <= 1'b1;
            sclk <= 1'b0;
            writeTake <= 1'b0;
            readData <= 8'h00;
            readValid <= 1'b0;
            outSync1 <= 1'b1;
            outSync2 <= 1'b1;
        end else begin
            state <= next_state;
            phase <= next_phase;
            bitCnt <= next_bitCnt;
            bytesLeft <= next_bytesLeft;
            txShift <= next_txShift;
            rxShift <= next_rxShift;
            isRead <= next_isRead;
            selN <= next_selN;
            sclk <= next_sclk;
            writeTake <= next_writeTake;
            readData <= next_readData;
            readValid <= next_readValid;
            outSync1 <= link.serialOutLine;
            outSync2 <= outSync1;
        end
    end

    assign link.serialClock = sclk;
    assign link.portSelectN = selN;
    assign link.serialIn = txShift[23];
    assign busy = state != ST_IDLE;
endmodule

//--- verif/serial_port_checker.sv
// link checker: timing and drive rules on the serial wires
`timescale 1ns/1ps
module serial_port_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic serialClock,
    input wire logic portSelectN,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEnN,
    input wire logic serialOutLine
);
    logic sclkQ;
    logic rwBit;
    logic [9:0] bitCnt;
    logic next_sclkQ;
    logic next_rwBit;
    logic [9:0] next_bitCnt;
    // counts rising link edges per frame; cleared while deselected
    always_comb begin
        next_sclkQ = serialClock;
        next_rwBit = rwBit;
        next_bitCnt = bitCnt;
        if (portSelectN) begin
            next_bitCnt = 10'h000;
        end else if (serialClock && !sclkQ) begin
            next_bitCnt = bitCnt + 10'h001;
            if (bitCnt == 10'h000) begin
                next_rwBit = serialIn;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sclkQ <= 1'b0;
            rwBit <= 1'b0;
            bitCnt <= 10'h000;
        end else begin
            sclkQ <= next_sclkQ;
            rwBit <= next_rwBit;
            bitCnt <= next_bitCnt;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_clk_idle; portSelectN |-> !serialClock; endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("link clock moved while deselected");
    property p_frame_len; $rose(portSelectN) |-> bitCnt >= 10'h018 && bitCnt[2:0] == 3'h0; endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not 24 bits plus whole bytes");
    property p_sclk_high; $rose(serialClock) |-> serialClock [*4] ##1 !serialClock; endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("high phase length wrong");
    property p_sclk_low; $fell(serialClock) |-> !serialClock [*4]; endproperty
    a_sclk_low: assert property (p_sclk_low) else $error("low phase too short");
    property p_din_stable; serialClock |-> $stable(serialIn); endproperty
    a_din_stable: assert property (p_din_stable) else $error("data in moved while clock high");
    property p_wr_hiz; !portSelectN && !rwBit && bitCnt != 10'h000 |-> serialOutEnN && serialOutLine; endproperty
    a_wr_hiz: assert property (p_wr_hiz) else $error("output driven in write frame");
    property p_rd_hdr_hiz; !portSelectN && rwBit && bitCnt inside {[1:15]} |-> serialOutEnN; endproperty
    a_rd_hdr_hiz: assert property (p_rd_hdr_hiz) else $error("output driven in read header");
    property p_rd_drive; $rose(rwBit && bitCnt == 10'h010) |-> ##[1:12] !serialOutEnN; endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
    property p_dout_fall; !serialOutEnN && $changed(serialOut) |-> !serialClock; endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("read data moved while clock high");
    property p_idle_hiz; portSelectN [*5] |-> serialOutEnN; endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("output driven while deselected");
endmodule

//--- verif/serial_port_tb_top.sv
// testbench: host and device ends over the link, plus a second device driven by a bit-banged host
`timescale 1ns/1ps
module serial_port_tb_top;
    import serial_port_pkg::*;
    localparam logic [14:0] RA [25] = '{15'h000, 15'h001, 15'h002, 15'h003, 15'h004, 15'h005, 15'h00c,
        15'h00d, 15'h010, 15'h029, 15'h02a, 15'h02b, 15'h02c, 15'h030, 15'h031, 15'h038, 15'h060,
        15'h064, 15'h068, 15'h06a, 15'h06e, 15'h07a, 15'h152, 15'h200, 15'h201};
    localparam logic [7:0] RV [25] = '{8'h30, 8'h00, 8'h00, 8'h3c, 8'h21, 8'h7e, 8'h19, 8'h5b, 8'h00,
        8'h00, 8'h00, 8'h11, 8'h6d, 8'h00, 8'ha0, 8'h00, 8'h01, 8'h02, 8'h61, 8'h3e, 8'h88, 8'h40, 8'h4b,
        8'h01, 8'h02};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic readNotWrite = 1'b0;
    logic [14:0] address = 15'h000;
    logic [7:0] byteCount = 8'h01;
    logic [7:0] hostWrData = 8'h00;
    logic calRunning = 1'b0;
    logic [7:0] syncPos = 8'h6d;
    logic [7:0] calSt = 8'h3e;
    logic [NUM_FUSE*8-1:0] fuse = 96'h4b4a49484746454443424140;
    logic writeTake, readValid, busy, devStrobe, devStrobe2;
    logic [7:0] readData, devData, devData2, g;
    logic [14:0] devAddr, devAddr2;
    logic [7:0] wbuf [4];
    logic [7:0] rbuf [8];
    logic [22:0] wq [$];
    logic [23:0] cap;
    int rn = 0;
    int strobes2 = 0;
    int error_cnt = 0;
    int n_checks = 0;
    serial_port_if lnk ();
    serial_port_if lnk2 ();
    serial_port_host i_serial_port_host (.clock(clock), .sys_rst(sys_rst), .link(lnk.host), .start(start),
        .readNotWrite(readNotWrite), .address(address), .byteCount(byteCount), .writeData(hostWrData),
        .calRunning(calRunning), .writeTake(writeTake), .readData(readData), .readValid(readValid), .busy(busy));
    // identity parameters: arbitrary values
    serial_port_device #(.PART_TYPE(8'h3c), .PART_ID(16'h7e21), .MAKER(16'h5b19)) i_serial_port_device (
        .clock(clock), .sys_rst(sys_rst), .link(lnk.device), .fuseTrim(fuse), .syncCapturePos(syncPos),
        .calState(calSt), .writeStrobe(devStrobe), .writeAddr(devAddr), .writeData(devData));
    serial_port_device i_serial_port_device_2 (
        .clock(clock), .sys_rst(sys_rst), .link(lnk2.device), .fuseTrim(fuse), .syncCapturePos(syncPos),
        .calState(calSt), .writeStrobe(devStrobe2), .writeAddr(devAddr2), .writeData(devData2));
    serial_port_checker i_serial_port_checker (.clock(clock), .sys_rst(sys_rst), .serialClock(lnk.serialClock),
        .portSelectN(lnk.portSelectN), .serialIn(lnk.serialIn), .serialOut(lnk.serialOut),
        .serialOutEnN(lnk.serialOutEnN), .serialOutLine(lnk.serialOutLine));

    always #5 clock = ~clock;
    // strobes sampled mid-cycle, clear of the edge that launches them
    always @(negedge clock) begin
        if (devStrobe === 1'b1) begin
            wq.push_back({devAddr, devData});
        end
        if (devStrobe2 === 1'b1) begin
            strobes2++;
        end
    end
    always @(posedge lnk.serialClock) begin
        if (!lnk.portSelectN) begin
            cap = {cap[22:0], lnk.serialIn};
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // next write byte is presented after each take pulse
    task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] n);
        int k;
        int t;
        k = 0;
        t = 0;
        rn = 0;
        wq.delete();
        readNotWrite = rw;
        address = a;
        byteCount = n;
        hostWrData = wbuf[0];
        start = 1'b1;
        // the first take pulse follows the start edge at once
        do begin
            @(negedge clock);
            start = 1'b0;
            if (writeTake === 1'b1 && k < 3) begin
                k++;
                hostWrData = wbuf[k];
            end
            if (readValid === 1'b1) begin
                rbuf[rn] = readData;
                rn++;
            end
            t++;
        end while ((t < 3 || busy === 1'b1) && t < 20000);
        if (t >= 20000) begin
            error_cnt++;
        end
        repeat (8) @(negedge clock);
    endtask
    task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
        xfer(1'b1, a, 8'h01);
        check(24'(rbuf[0]), 24'(e));
    endtask
    task automatic refuse(input logic rw, input logic [14:0] a, input logic cal);
        readNotWrite = rw;
        address = a;
        calRunning = cal;
        start = 1'b1;
        repeat (3) @(negedge clock);
        check(24'(busy), 24'h0);
        start = 1'b0;
        calRunning = 1'b0;
        @(negedge clock);
    endtask
    // raw frame on the second link, 80 ns bit period, sampling output on rising
    task automatic bang(input logic [23:0] v, input int nb);
        lnk2.portSelectN = 1'b0;
        repeat (4) @(negedge clock);
        for (int i = 0; i < nb; i++) begin
            lnk2.serialIn = v[23-i];
            repeat (4) @(negedge clock);
            lnk2.serialClock = 1'b1;
            g = {g[6:0], lnk2.serialOutLine};
            repeat (4) @(negedge clock);
            lnk2.serialClock = 1'b0;
        end
        repeat (4) @(negedge clock);
        lnk2.portSelectN = 1'b1;
        repeat (8) @(negedge clock);
    endtask

    initial begin
        lnk2.serialClock = 1'b0;
        lnk2.portSelectN = 1'b1;
        lnk2.serialIn = 1'b0;
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        for (int i = 0; i < 25; i++) begin
            rdchk(RA[i], RV[i]);
        end
        syncPos = 8'h93;
        calSt = 8'hc4;
        rdchk(15'h02c, 8'h93);
        rdchk(15'h06a, 8'hc4);
        wbuf = '{8'h5c, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, 15'h029, 8'h01);
        check(cap, {1'b0, 15'h029, 8'h5c});
        check(24'(wq.size()), 24'h1);
        check(24'(wq[0]), 24'h00295c);
        rdchk(15'h029, 8'h5c);
        wbuf = '{8'h11, 8'h22, 8'h33, 8'h00};
        xfer(1'b0, 15'h029, 8'h03);
        check(24'(wq[2]), {1'b0, 15'h02b, 8'h33});
        xfer(1'b1, 15'h029, 8'h03);
        check({rbuf[0], rbuf[1], rbuf[2]}, 24'h112233);
        wbuf = '{8'h3a, 8'h3b, 8'h00, 8'h00};
        xfer(1'b0, 15'h07a, 8'h02);
        check(24'(wq[1]), {1'b0, 15'h07b, 8'h3b});
        wbuf = '{8'h04, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, 15'h000, 8'h01);
        rdchk(15'h000, 8'h24);
        wbuf = '{8'h00, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, 15'h000, 8'h01);
        wbuf = '{8'h9a, 8'h9b, 8'h00, 8'h00};
        xfer(1'b0, 15'h062, 8'h02);
        check(24'(wq[1]), {1'b0, 15'h061, 8'h9b});
        wbuf = '{8'h20, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, 15'h000, 8'h01);
        xfer(1'b1, 15'h000, 8'h02);
        check({8'h00, rbuf[0], rbuf[1]}, 24'h002400);
        // read-only byte inside a stream must be dropped
        wbuf = '{8'h07, 8'hff, 8'h00, 8'h00};
        xfer(1'b0, 15'h002, 8'h02);
        check(24'(wq.size()), 24'h1);
        rdchk(15'h003, 8'h3c);
        wbuf = '{8'h01, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, 15'h010, 8'h01);
        wbuf = '{8'hc1, 8'hc2, 8'hc3, 8'h00};
        xfer(1'b0, 15'h038, 8'h03);
        check(24'(wq[2]), {1'b0, 15'h038, 8'hc3});
        check(24'(wq.size()), 24'h3);
        rdchk(15'h038, 8'hc3);
        wbuf = '{8'h00, 8'h00, 8'h00, 8'h00};
        xfer(1'b0, 15'h010, 8'h01);
        refuse(1'b1, 15'h000, 1'b1);
        refuse(1'b0, 15'h001, 1'b0);
        bang({1'b0, 15'h038, 8'h77}, 20);
        check(24'(strobes2), 24'h0);
        bang({1'b0, 15'h038, 8'h5a}, 24);
        check({strobes2[0], devAddr2, devData2}, {1'b1, 15'h038, 8'h5a});
        bang({1'b1, 15'h038, 8'h00}, 24);
        check(24'(g), 24'h5a);
        end_of_test();
    end
    initial begin
        #500000;
        error_cnt++;
        end_of_test();
    end
endmodule
